// [hw/fwsi_dev.sv]
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Flash register interface: control registers, busy and lock flags, array read trap
module fwsi_dev
  import fwsi_pkg::*;
(
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Synchronous reset, active high
  fwsi_if.dev              link,         // Register and array port
  input  wire logic        lvd_i,        // Supply drop monitor, asynchronous pin
  input  wire logic        bootstrap_i,  // Bootstrap mode, asynchronous pin
  input  wire logic [15:0] arr_rdata_i,  // Array read data, sampled in the cycle arr_rd_o is high
  input  wire logic        op_done_i,    // Engine finished the operation, one-cycle pulse
  input  wire logic        op_susp_i,    // Engine suspend took effect, one-cycle pulse
  input  wire logic [15:0] op_err_i,     // Engine error flags, sampled with op_done_i
  output logic             arr_rd_o,     // Array read strobe
  output logic             arr_wr_o,     // Array write strobe
  output logic      [23:0] arr_addr_o,   // Array address
  output logic      [15:0] arr_wdata_o,  // Array write data
  output logic      [1:0]  arr_be_o,     // Array byte enables
  output logic             arr_tsec_o,   // Read goes to the test sector
  output logic             op_start_o,   // Start pulse to the engine
  output logic      [15:0] op_cmd_o,     // Command word with operation selects
  output logic      [31:0] op_addr_o,    // Program address
  output logic      [63:0] op_data_o,    // Program data, odd word high
  output logic             busy_o        // Any busy flag set
);
  import fwsi_pkg::*;

  typedef struct packed {
    logic                       lvd_m;
    logic                       lvd_s;
    logic                       boot_m;
    logic                       boot_s;
    logic                       stage;
    logic                       trap;
    logic                       ack;
    logic [15:0]                rdata;
    logic [NREG-1:0][15:0]      regs;
    logic                       bank_busy;
    logic                       nvr;
    logic                       lock;
    logic                       arr_rd;
    logic                       arr_wr;
    logic                       tsec;
    logic [23:0]                arr_addr;
    logic [15:0]                arr_wdata;
    logic [1:0]                 arr_be;
    logic                       op_start;
  } fwsi_dev_s;

  fwsi_dev_s   s_q;
  fwsi_dev_s   s_d;
  logic        in_regs;
  logic        in_arr;
  logic        busy;
  logic [3:0]  idx;
  logic [15:0] status;
  logic [15:0] merged;

  // Status word composed from the flags, reserved bits stay zero
  function automatic logic [15:0] fwsi_status(input logic bank_busy, input logic lock,
                                              input logic nvr);
    logic [15:0] w;
    w = ZERO_WORD;
    w[B_DUMMY] = bank_busy;
    w[B_BANK0] = bank_busy;
    w[B_LOCK]  = lock;
    w[B_NVR]   = nvr;
    return w;
  endfunction

  assign in_regs = (link.addr >= REG_BASE) && (link.addr <= REG_LAST);
  assign in_arr  = link.addr <= ARR_LAST;
  assign idx     = link.addr[4:1];
  assign busy    = s_q.bank_busy | s_q.nvr;
  assign status  = fwsi_status(s_q.bank_busy, s_q.lock, s_q.nvr);
  assign merged  = fwsi_merge(s_q.regs[idx], link.wdata, link.be);

  // Two-stage access: stage 0 issues to the array, stage 1 answers and commits
  always_comb begin
    s_d          = s_q;
    s_d.lvd_m    = lvd_i;
    s_d.lvd_s    = s_q.lvd_m;
    s_d.boot_m   = bootstrap_i;
    s_d.boot_s   = s_q.boot_m;
    s_d.ack      = 1'b0;
    s_d.arr_rd   = 1'b0;
    s_d.arr_wr   = 1'b0;
    s_d.op_start = 1'b0;

    // End of operation or suspend returns to read mode
    if (op_done_i || op_susp_i) begin
      s_d.bank_busy = 1'b0;
      s_d.nvr       = 1'b0;
      s_d.lock      = 1'b0;
      s_d.regs[IDX_CMD][B_START] = 1'b0;
    end
    // Error flags land only as the busy flags drop
    if (op_done_i) begin
      s_d.regs[IDX_ERR] = op_err_i;
      s_d.regs[IDX_CMD] = s_d.regs[IDX_CMD] & ~OPSEL_MASK;
    end
    if (s_q.lvd_s) begin
      s_d.bank_busy = 1'b0;
      s_d.nvr       = 1'b0;
      s_d.lock      = 1'b0;
      s_d.regs[IDX_CMD][B_START] = 1'b0;
    end

    if (link.req && !s_q.ack && !s_q.stage) begin
      s_d.stage = 1'b1;
      s_d.trap  = 1'b0;
      if (in_arr) begin
        if (busy) begin
          s_d.trap = 1'b1;
        end else if (link.we && link.addr <= TSEC_LAST) begin
          s_d.trap = 1'b1;
        end else begin
          s_d.arr_rd    = ~link.we;
          s_d.arr_wr    = link.we;
          s_d.arr_addr  = link.addr;
          s_d.arr_wdata = link.wdata;
          s_d.arr_be    = link.be;
          s_d.tsec      = s_q.boot_s && !link.we && link.addr <= TSEC_LAST;
        end
      end
    end else if (s_q.stage) begin
      s_d.stage = 1'b0;
      s_d.ack   = 1'b1;
      s_d.rdata = ZERO_WORD;
      if (in_arr) begin
        s_d.rdata = s_q.trap ? TRAP_WORD : arr_rdata_i;
      end else if (in_regs && link.flash_iface_enable) begin
        if (idx == IDX_STATUS) begin
          s_d.rdata = status;
        end else if (s_q.lock) begin
          s_d.rdata = TRAP_WORD;
        end else begin
          s_d.rdata = s_q.regs[idx];
          if (link.we && idx == IDX_CMD) begin
            s_d.regs[IDX_CMD] = (s_d.regs[IDX_CMD] & ~CMD_WMASK) | (merged & CMD_WMASK);
            // Start accepted only with no pending error
            if (merged[B_START] && !s_q.regs[IDX_ERR][B_ERR] && !s_q.lvd_s) begin
              s_d.regs[IDX_CMD][B_START] = 1'b1;
              s_d.op_start = 1'b1;
              s_d.lock = 1'b1;
              if (s_q.regs[IDX_ADDR_H][7:0] == NVR_PAGE) begin
                s_d.nvr = 1'b1;
              end else begin
                s_d.bank_busy = 1'b1;
              end
            end
          end else if (link.we) begin
            s_d.regs[idx] = merged;
          end
        end
      end
    end
  end

  // Single register for all state; reset clears every flag and register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flops, busy_o from an OR of two of them
  assign link.ack    = s_q.ack;
  assign link.rdata  = s_q.rdata;
  assign arr_rd_o    = s_q.arr_rd;
  assign arr_wr_o    = s_q.arr_wr;
  assign arr_addr_o  = s_q.arr_addr;
  assign arr_wdata_o = s_q.arr_wdata;
  assign arr_be_o    = s_q.arr_be;
  assign arr_tsec_o  = s_q.tsec;
  assign op_start_o  = s_q.op_start;
  assign op_cmd_o    = s_q.regs[IDX_CMD];
  assign op_addr_o   = {s_q.regs[IDX_ADDR_H], s_q.regs[IDX_ADDR_H-4'h1]};
  assign op_data_o   = {s_q.regs[7], s_q.regs[6], s_q.regs[5], s_q.regs[4]};
  assign busy_o      = busy;
endmodule
`default_nettype wire

// [hw/fwsi_pkg.sv]
// What this block does
// - Registers decode in 0x0E0000 to 0x0E0015
// - Four control plus address, data, error registers
// - Byte and halfword accesses on every register
// - Registers reachable only with enable bit 5
// - Busy array reads return 009Bh
// - Controller code runs outside the flash array
// - No register writes while lock is set
// - Supply drop aborts operation, back to read
// - Test sector never writable, visible in bootstrap
// - Status low resets zero, reserved bits zero
// - Bit 6 mirrors bank zero busy
// - Bank busy: reads trap, writes discarded
// - Busy clears on done or suspend, resume sets
// - Lock sets with start; registers trap, ignore writes
// - Lock always readable; software waits for low
// - Non-volatile busy sets with start, traps array
// - Write start bit 15; hardware clears it
package fwsi_pkg;
  localparam int          ADDR_W     = 24;
  localparam int          DATA_W     = 16;
  localparam int          NREG       = 11;
  // Device address map
  localparam logic [23:0] REG_BASE   = 24'h0E0000;
  localparam logic [23:0] REG_LAST   = 24'h0E0015;
  localparam logic [23:0] ARR_LAST   = 24'h08FFFF;
  localparam logic [23:0] TSEC_LAST  = 24'h000FFF;
  localparam logic [15:0] TRAP_WORD  = 16'h009B;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  // Register indices, byte offset divided by two
  localparam logic [3:0]  IDX_STATUS = 4'h0;
  localparam logic [3:0]  IDX_CMD    = 4'h1;
  localparam logic [3:0]  IDX_ADDR_H = 4'h9;
  localparam logic [3:0]  IDX_ERR    = 4'hA;
  // Status and command fields
  localparam int          B_DUMMY    = 6;
  localparam int          B_BANK0    = 5;
  localparam int          B_LOCK     = 4;
  localparam int          B_NVR      = 1;
  localparam int          B_START    = 15;
  localparam int          B_ERR      = 0;
  localparam logic [15:0] CMD_WMASK  = 16'h7980;
  localparam logic [15:0] OPSEL_MASK = 16'h3800;
  localparam logic [7:0]  NVR_PAGE   = 8'h0E;
  // Controller software map, byte addresses on Wishbone
  localparam logic [7:0]  HA_ADDR    = 8'h00;
  localparam logic [7:0]  HA_WDATA   = 8'h04;
  localparam logic [7:0]  HA_CMD     = 8'h08;
  localparam logic [7:0]  HA_RDATA   = 8'h0C;
  localparam logic [7:0]  HA_CFG     = 8'h10;
  localparam int          HC_GO      = 0;
  localparam int          HC_WE      = 1;
  localparam int          HC_BE      = 2;
  localparam int          CFG_EN_BIT = 5;

  typedef logic [15:0] fwsi_word_t;

  // Byte-lane merge of a write into a 16-bit register
  function automatic fwsi_word_t fwsi_merge(input fwsi_word_t old_v, input fwsi_word_t new_v,
                                            input logic [1:0] be);
    fwsi_word_t r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction
endpackage

// [hw/fwsi_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Register port between controller and flash interface
interface fwsi_if;
  import fwsi_pkg::*;
  logic              flash_iface_enable; // Enable bit of the peripheral configuration
  logic              req;                // Request, held until ack
  logic              we;                 // Write when high
  logic [1:0]        be;                 // Byte enables, bit 0 low byte
  logic [ADDR_W-1:0] addr;               // Byte address
  logic [DATA_W-1:0] wdata;              // Write data
  logic              ack;                // One-cycle answer
  logic [DATA_W-1:0] rdata;              // Read data, valid with ack

  modport dev (input flash_iface_enable, req, we, be, addr, wdata, output ack, rdata);
  modport ctl (output flash_iface_enable, req, we, be, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// [hw/fwsi_ctl.sv]
`timescale 1ns/1ps
`default_nettype none
// Controller end: software orders over Wishbone, one transfer at a time on the link
module fwsi_ctl
  import fwsi_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Synchronous reset, active high
  input  wire logic        wb_cyc_i,  // Wishbone cycle
  input  wire logic        wb_stb_i,  // Wishbone strobe
  input  wire logic        wb_we_i,   // Wishbone write
  input  wire logic [7:0]  wb_adr_i,  // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,  // Wishbone byte selects
  input  wire logic [31:0] wb_dat_i,  // Wishbone write data
  output logic      [31:0] wb_dat_o,  // Wishbone read data
  output logic             wb_ack_o,  // Wishbone acknowledge
  fwsi_if.ctl              link       // Flash register port
);
  import fwsi_pkg::*;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic [1:0]  be;
    logic        req;
    logic [15:0] rdata;
    logic [15:0] cfg;
  } fwsi_ctl_s;

  fwsi_ctl_s s_q;
  fwsi_ctl_s s_d;
  logic      wb_hit;
  logic [31:0] wv;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~s_q.ack;

  // Bus slave and link master; a new go is ignored while a transfer is pending
  always_comb begin
    s_d = s_q;
    s_d.ack = wb_hit;
    wv = wb_dat_i;
    if (s_q.req && link.ack) begin
      s_d.req = 1'b0;
      if (!s_q.we) begin
        s_d.rdata = link.rdata;
      end
    end
    if (wb_hit) begin
      s_d.dat = 32'h00000000;
      unique case (wb_adr_i)
        HA_ADDR: begin
          s_d.dat = {8'h00, s_q.addr};
          if (wb_we_i && !s_q.req) begin
            if (wb_sel_i[0]) s_d.addr[7:0] = wv[7:0];
            if (wb_sel_i[1]) s_d.addr[15:8] = wv[15:8];
            if (wb_sel_i[2]) s_d.addr[23:16] = wv[23:16];
          end
        end
        HA_WDATA: begin
          s_d.dat = {16'h0000, s_q.wdata};
          if (wb_we_i && !s_q.req) begin
            s_d.wdata = fwsi_merge(s_q.wdata, wv[15:0], wb_sel_i[1:0]);
          end
        end
        HA_CMD: begin
          s_d.dat = {28'h0000000, s_q.be, s_q.we, s_q.req};
          if (wb_we_i && wb_sel_i[0] && !s_q.req) begin
            s_d.we  = wv[HC_WE];
            s_d.be  = wv[HC_BE+1:HC_BE];
            s_d.req = wv[HC_GO];
          end
        end
        HA_RDATA: begin
          s_d.dat = {16'h0000, s_q.rdata};
        end
        HA_CFG: begin
          s_d.dat = {16'h0000, s_q.cfg};
          if (wb_we_i) begin
            s_d.cfg = fwsi_merge(s_q.cfg, wv[15:0], wb_sel_i[1:0]);
          end
        end
        default: begin
          s_d.dat = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Link outputs straight from the state flops
  assign wb_ack_o                = s_q.ack;
  assign wb_dat_o                = s_q.dat;
  assign link.flash_iface_enable = s_q.cfg[CFG_EN_BIT];
  assign link.req                = s_q.req;
  assign link.we                 = s_q.we;
  assign link.be                 = s_q.be;
  assign link.addr               = s_q.addr;
  assign link.wdata              = s_q.wdata;
endmodule
`default_nettype wire

// [verif/fwsi_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the link between controller end and device end
module fwsi_checker
  import fwsi_pkg::*;
(
  input  wire logic        clk_i,              // System clock
  input  wire logic        rst_i,              // Reset, active high
  input  wire logic        flash_iface_enable, // Register window enable
  input  wire logic        req,                // Link request
  input  wire logic        we,                 // Link write
  input  wire logic [23:0] addr,               // Link byte address
  input  wire logic        ack,                // Link answer
  input  wire logic [15:0] rdata               // Link read data
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Read answers, and those that hit the status halfword
  logic rd_ack;
  logic st_rd;
  assign rd_ack = ack && !we;
  assign st_rd  = rd_ack && flash_iface_enable && (addr[23:1] == REG_BASE[23:1]);

  property p_ack_lat; $rose(req) |-> ##[1:3] ack; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("link answer late");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("link answer too long");
  property p_ack_req; ack |-> req; endproperty
  a_ack_req: assert property (p_ack_req) else $error("answer without request");
  property p_req_hold; req && !ack |=> req && $stable(addr) && $stable(we); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed early");
  property p_en;
    rd_ack && !flash_iface_enable && addr >= REG_BASE && addr <= REG_LAST |-> rdata == ZERO_WORD;
  endproperty
  a_en: assert property (p_en) else $error("window read while disabled");
  property p_rsv; st_rd |-> (rdata & 16'hFF8D) == ZERO_WORD; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  property p_mirror; st_rd |-> rdata[B_DUMMY] == rdata[B_BANK0]; endproperty
  a_mirror: assert property (p_mirror) else $error("bank one busy not a mirror");
  property p_unmap;
    rd_ack && addr > ARR_LAST && (addr < REG_BASE || addr > REG_LAST) |-> rdata == ZERO_WORD;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Main traffic kinds
  c_wr: cover property (ack && we);
  c_rd: cover property (st_rd && rdata[B_LOCK]);
  c_off: cover property (rd_ack && !flash_iface_enable);
endmodule
`default_nettype wire

// [verif/tb_flash_write_status_interface.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_flash_write_status_interface;
  import fwsi_pkg::*;
  typedef struct packed {
    logic [23:0] a;
    logic        w;
    logic [1:0]  be;
    logic [15:0] wd;
    logic [15:0] ex;
  } fwsi_row_s;
  // Register traffic plus one unmapped and one array read: optional write, then read back
  localparam fwsi_row_s ROWS [9] = '{
    '{24'h0E0010, 1'b1, 2'h3, 16'h1234, 16'h1234}, '{24'h0E0012, 1'b1, 2'h1, 16'h00AB, 16'h00AB},
    '{24'h0E0012, 1'b1, 2'h2, 16'hCD00, 16'hCDAB}, '{24'h0E0008, 1'b1, 2'h3, 16'h5555, 16'h5555},
    '{24'h0E000E, 1'b1, 2'h3, 16'hAAAA, 16'hAAAA}, '{24'h0E0000, 1'b1, 2'h3, 16'hFFFF, 16'h0000},
    '{24'h0E0016, 1'b0, 2'h3, 16'h0000, 16'h0000}, '{24'h000100, 1'b0, 2'h3, 16'h0000, 16'h0E0F},
    '{24'h0E0014, 1'b0, 2'h3, 16'h0000, 16'h0000}};
  logic        clk_i, rst_i, cyc, stb, wwe, lvd, boot, done, susp, ack_o, ard, awr, tsec, busy;
  logic        tsec_seen, ostart;
  logic [1:0]  abe;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat_o, r, oaddr;
  logic [63:0] odata;
  logic [15:0] ardata, err, d, n, wr_cnt, st_cnt, ocmd, awd;
  logic [23:0] aaddr;
  int          bad_count, samples_checked, cyc_cnt;
  fwsi_if lnk ();
  fwsi_ctl fwsi_ctl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat_o),
    .wb_ack_o(ack_o), .link(lnk));
  fwsi_dev fwsi_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .lvd_i(lvd), .bootstrap_i(boot),
    .arr_rdata_i(ardata), .op_done_i(done), .op_susp_i(susp), .op_err_i(err), .arr_rd_o(ard),
    .arr_wr_o(awr), .arr_addr_o(aaddr), .arr_wdata_o(awd), .arr_be_o(abe), .arr_tsec_o(tsec),
    .op_start_o(ostart), .op_cmd_o(ocmd), .op_addr_o(oaddr), .op_data_o(odata), .busy_o(busy));
  fwsi_checker fwsi_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .flash_iface_enable(lnk.flash_iface_enable), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
    .ack(lnk.ack), .rdata(lnk.rdata));
  // Array content is its own address scrambled, so a stale word shows
  assign ardata = aaddr[15:0] ^ 16'h0F0F;

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Array write strobes, engine start pulses and the test sector flag seen, and a hang limit well above the expected run
  always @(posedge clk_i) begin
    if (awr === 1'b1) begin
      wr_cnt <= wr_cnt + 16'h1;
    end
    if (ostart === 1'b1) begin
      st_cnt <= st_cnt + 16'h1;
    end
    if (ard === 1'b1) begin
      tsec_seen <= tsec;
    end
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      bad_count = bad_count + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic c16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic c1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    wdat <= dt;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = rdat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // One link transfer ordered through the controller registers
  task automatic lk(input logic [23:0] a, input logic w, input logic [1:0] be,
                    input logic [15:0] dt);
    wb(1'b1, HA_ADDR, {8'h00, a});
    wb(1'b1, HA_WDATA, {16'h0000, dt});
    wb(1'b1, HA_CMD, {28'h0000000, be, w, 1'b1});
    do wb(1'b0, HA_CMD, 32'h00000000); while (r[0] !== 1'b0);
    wb(1'b0, HA_RDATA, 32'h00000000);
    d = r[15:0];
  endtask
  task automatic rc(input string nm, input logic [23:0] a, input logic [15:0] e);
    lk(a, 1'b0, 2'h3, 16'h0000);
    c16(nm, e, d);
  endtask
  // Engine end pulse: suspend when sp is high, completion otherwise
  task automatic fin(input logic sp);
    @(posedge clk_i);
    susp <= sp;
    done <= !sp;
    @(posedge clk_i);
    susp <= 1'b0;
    done <= 1'b0;
  endtask

  // Orders come from the bench, never from the array
  initial begin
    {cyc, stb, wwe, lvd, boot, done, susp, tsec_seen} = 8'h00;
    adr = 8'h00;
    wdat = 32'h00000000;
    err = 16'h0000;
    wr_cnt = 16'h0000;
    st_cnt = 16'h0000;
    bad_count = 0;
    samples_checked = 0;
    cyc_cnt = 0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    c1("busy_rst", 1'b0, busy);
    rc("off_rd", 24'h0E0000, 16'h0000);
    lk(24'h0E0010, 1'b1, 2'h3, 16'h1111);
    wb(1'b1, HA_CFG, 32'h00000020);
    rc("off_wr", 24'h0E0010, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      if (ROWS[i].w) begin
        lk(ROWS[i].a, 1'b1, ROWS[i].be, ROWS[i].wd);
      end
      rc("row", ROWS[i].a, ROWS[i].ex);
    end
    c16("op_addr_lo", 16'h1234, oaddr[15:0]);
    c16("op_addr_hi", 16'hCDAB, oaddr[31:16]);
    c16("op_data_lo", 16'h5555, odata[15:0]);
    c16("op_data_hi", 16'hAAAA, odata[63:48]);
    n = wr_cnt;
    lk(24'h0E0002, 1'b1, 2'h3, 16'hA000);
    rc("run", 24'h0E0000, 16'h0070);
    c1("busy_run", 1'b1, busy);
    c16("starts", 16'h0001, st_cnt);
    c16("cmd_out", 16'hA000, ocmd);
    rc("lock_rd", 24'h0E0010, TRAP_WORD);
    lk(24'h0E0010, 1'b1, 2'h3, 16'h7777);
    lk(24'h010000, 1'b1, 2'h3, 16'h0000);
    rc("arr_trap", 24'h000100, TRAP_WORD);
    fin(1'b1);
    rc("susp", 24'h0E0000, 16'h0000);
    rc("susp_cmd", 24'h0E0002, 16'h2000);
    rc("lock_wr", 24'h0E0010, 16'h1234);
    lk(24'h0E0002, 1'b1, 2'h3, 16'hA000);
    rc("resume", 24'h0E0000, 16'h0070);
    err <= 16'h0002;
    fin(1'b0);
    rc("done_cmd", 24'h0E0002, 16'h0000);
    rc("err", 24'h0E0014, 16'h0002);
    c16("busy_wr", n, wr_cnt);
    lk(24'h0E0012, 1'b1, 2'h3, 16'h000E);
    lk(24'h0E0002, 1'b1, 2'h3, 16'hA000);
    rc("nvr", 24'h0E0000, 16'h0012);
    rc("nvr_trap", 24'h000100, TRAP_WORD);
    fin(1'b0);
    lk(24'h0E0002, 1'b1, 2'h3, 16'hA000);
    @(posedge clk_i);
    lvd <= 1'b1;
    repeat (5) @(posedge clk_i);
    lvd <= 1'b0;
    rc("drop", 24'h0E0000, 16'h0000);
    c1("drop_busy", 1'b0, busy);
    lk(24'h000010, 1'b1, 2'h3, 16'h0000);
    c16("tsec_wr", n, wr_cnt);
    lk(24'h010000, 1'b1, 2'h1, 16'h5A5A);
    c16("idle_wr", n + 16'h1, wr_cnt);
    c16("arr_wd", 16'h5A5A, awd);
    c16("arr_be", 16'h0001, {14'h0000, abe});
    lk(24'h000010, 1'b0, 2'h3, 16'h0000);
    c1("tsec_user", 1'b0, tsec_seen);
    boot <= 1'b1;
    repeat (4) @(posedge clk_i);
    lk(24'h000010, 1'b0, 2'h3, 16'h0000);
    c1("tsec_boot", 1'b1, tsec_seen);
    err <= 16'h0001;
    fin(1'b0);
    lk(24'h0E0002, 1'b1, 2'h3, 16'hA000);
    rc("err_block", 24'h0E0000, 16'h0000);
    c16("no_start", 16'h0004, st_cnt);
    end_of_test();
  end
endmodule
`default_nettype wire
